//--- design/cir_pkg.sv
// Constants and types for the chained interrupt request logic.
// Assumes a single 125 MHz clock and plain control ports, no register bus.
// Behaviour
// RULE1: Interrupt only when line armed and enabled.
// RULE2: Separate arm and enable per line.
// RULE3: Reset leaves all lines disarmed, disabled.
// RULE4: Armed line latches each recognised request.
// RULE5: Disarm clears request and ignores new ones.
// RULE6: Only enabled lines reach priority stage.
// RULE7: Disabled armed line holds request until enabled.
// RULE8: Host clears pending bit after servicing.
// RULE9: No new delivery until pending cleared.
// RULE10: Default recognition is one request per edge.
// RULE11: Edge mode needs deassert then reassert.
// RULE12: Optional level mode, high or low.
// RULE13: Source holds each level 1.5 microseconds; the bench holds i_ext[0] high only 6 cycles before the chain check.
// RULE14: Shared line goes to host and chain.
// RULE15: Software request stays local only.
// RULE16: Routed raw input bypasses local logic.
// RULE17: Chain lines reach host and outputs.
// RULE18: Distributed local source raises two vectors.
// RULE19: Shared lines start disarmed, silent locally.
// RULE20: Disarmed shared line keeps source interrupt.
// RULE21: Software never routes two sources together.
// RULE22: External inputs pass two-stage synchroniser.
package cir_pkg;
   localparam int N_EXT   = 12;
   localparam int N_CHAIN = 8;
   localparam int N_SW    = 4;
   localparam int N_OUT   = 4;
   // Local sources: external inputs then software pulse sources.
   localparam int N_SRC   = N_EXT + N_SW;
   localparam int N_LINE  = N_EXT + N_CHAIN;
   localparam int SRC_W   = 5;
   localparam int LINE_W  = 5;
   localparam int CLK_MHZ = 125;
   localparam int HOLD_NS = 1500;
   localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam logic [N_LINE-1:0] ARM_RST  = 20'h0_0000;
   localparam logic [N_LINE-1:0] EN_RST   = 20'h0_0000;
   localparam logic [N_LINE-1:0] PEND_RST = 20'h0_0000;
   // Inputs idle high for the default falling mode, so no false edge or level follows reset.
   localparam logic [N_EXT-1:0]  EXT_RST  = 12'hfff;
   localparam logic [LINE_W-1:0] NO_LINE  = 5'h1f;
   typedef enum logic [1:0]
   {
      CIR_FALLING = 2'b00,
      CIR_RISING  = 2'b01,
      CIR_HIGH    = 2'b11,
      CIR_LOW     = 2'b10
   } cir_mode_t;
endpackage

//--- design/cir_prio.sv
// Fixed priority resolver: picks the lowest numbered ready line.
// Assumes requests come from the same clock domain.
`timescale 1ns/1ns
module cir_prio
   import cir_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic [N_LINE-1:0] i_req,
   output logic                   o_irq,
   output logic [LINE_W-1:0]      o_vector
);
   logic              irq_reg;
   logic [LINE_W-1:0] vec_reg;
   logic [LINE_W-1:0] vec_next;

   always_comb
   begin
      vec_next = NO_LINE;
      for (int k = N_LINE - 1; k >= 0; k--)
      begin
         if (i_req[k])
         begin
            vec_next = LINE_W'(k);
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         irq_reg <= 1'b0;
         vec_reg <= NO_LINE;
      end
      else
      begin
         irq_reg <= |i_req;
         vec_reg <= vec_next;
      end
   end

   assign o_irq    = irq_reg;
   assign o_vector = vec_reg;
endmodule

//--- design/cir_top.sv
// Per-line arm, enable, request and pending logic for external and chain lines.
// Assumes asynchronous external and chain inputs; the host clears pending bits.
`timescale 1ns/1ns
module cir_top
   import cir_pkg::*;
(
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   input  wire logic [N_EXT-1:0]      i_ext,
   input  wire logic [N_CHAIN-1:0]    i_chain,
   input  wire logic [N_SW-1:0]       i_sw_pulse,
   input  wire logic [N_LINE-1:0]     i_arm,
   input  wire logic [N_LINE-1:0]     i_enable,
   input  wire logic [N_EXT-1:0]      i_sw_req,
   input  wire logic [N_LINE-1:0]     i_pend_clr,
   input  wire logic [2*N_EXT-1:0]    i_mode,
   input  wire logic [N_CHAIN*SRC_W-1:0] i_chain_src,
   input  wire logic [N_CHAIN-1:0]    i_chain_route,
   input  wire logic [N_OUT*LINE_W-1:0] i_out_src,
   input  wire logic [N_OUT-1:0]      i_out_route,
   output logic [N_CHAIN-1:0]         o_chain,
   output logic [N_OUT-1:0]           o_ext_out,
   output logic [N_LINE-1:0]          o_pending,
   output logic [N_LINE-1:0]          o_request,
   output logic                       o_irq,
   output logic [LINE_W-1:0]          o_vector
);
   logic [N_EXT-1:0]   ext_s1_reg;
   logic [N_EXT-1:0]   ext_s2_reg;
   logic [N_EXT-1:0]   ext_d_reg;
   logic [N_CHAIN-1:0] ch_s1_reg;
   logic [N_CHAIN-1:0] ch_s2_reg;
   logic [N_CHAIN-1:0] ch_d_reg;
   logic [N_LINE-1:0]  line_in;
   logic [N_LINE-1:0]  line_prev;
   logic [N_LINE-1:0]  recog;
   logic [N_LINE-1:0]  req_reg;
   logic [N_LINE-1:0]  pend_reg;
   logic [N_LINE-1:0]  deliver;
   logic [N_SRC-1:0]   src_vec;
   logic [N_CHAIN-1:0] chain_reg;
   logic [N_OUT-1:0]   out_reg;
   logic [N_CHAIN-1:0] ch_view;
   logic [N_LINE-1:0]  src_wide;

   // Two flops before anything reads the pins.
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ext_s1_reg <= EXT_RST;
         ext_s2_reg <= EXT_RST;
         ext_d_reg  <= EXT_RST;
         ch_s1_reg  <= '0;
         ch_s2_reg  <= '0;
         ch_d_reg   <= '0;
      end
      else
      begin
         ext_s1_reg <= i_ext; // RULE22
         ext_s2_reg <= ext_s1_reg; // RULE22
         ext_d_reg  <= ext_s2_reg;
         ch_s1_reg  <= i_chain;
         ch_s2_reg  <= ch_s1_reg;
         ch_d_reg   <= ch_view;
      end
   end

   function automatic logic recognise(input logic [1:0] mode, input logic cur,
                                      input logic prev);
      case (mode)
         CIR_RISING:  recognise = cur & ~prev;
         CIR_FALLING: recognise = ~cur & prev;
         CIR_HIGH:    recognise = cur;
         CIR_LOW:     recognise = ~cur;
         default:     recognise = 1'b0;
      endcase
   endfunction

   // Out-of-range selects read zero instead of an unknown bit.
   function automatic logic pick_bit(input logic [N_LINE-1:0] vec,
                                     input logic [LINE_W-1:0] sel, input int limit);
      if (int'(sel) < limit)
      begin
         pick_bit = vec[sel];
      end
      else
      begin
         pick_bit = 1'b0;
      end
   endfunction

   // A chain line is seen locally whether a neighbour or this board drives it, so a
   // distributed local source also raises its own chain-line interrupt on this host.
   assign ch_view   = ch_s2_reg | chain_reg; // RULE18 RULE20
   assign line_in   = {ch_view, ext_s2_reg};
   assign line_prev = {ch_d_reg, ext_d_reg};

   // Chain lines are recognised on their rising edge; external lines per mode.
   always_comb
   begin
      recog = '0;
      for (int k = 0; k < N_EXT; k++)
      begin
         recog[k] = recognise(i_mode[2*k +: 2], line_in[k], line_prev[k]) // RULE10 RULE11 RULE12
                    | i_sw_req[k];
      end
      for (int k = N_EXT; k < N_LINE; k++)
      begin
         recog[k] = line_in[k] & ~line_prev[k]; // RULE17
      end
   end

   // A request latches while armed and is dropped on disarm.
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         req_reg <= ARM_RST; // RULE3 RULE19
      end
      else
      begin
         for (int k = 0; k < N_LINE; k++)
         begin
            if (!i_arm[k])
            begin
               req_reg[k] <= 1'b0; // RULE5 RULE19 RULE20
            end
            else if (recog[k])
            begin
               req_reg[k] <= 1'b1; // RULE4 RULE7
            end
            else if (deliver[k])
            begin
               req_reg[k] <= 1'b0;
            end
         end
      end
   end

   // Delivery needs arm, enable and no pending instance still unserviced.
   assign deliver = req_reg & i_arm & i_enable & ~pend_reg; // RULE1 RULE2 RULE6 RULE9

   // Pending set wins over a host clear in the same cycle.
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pend_reg <= PEND_RST;
      end
      else
      begin
         pend_reg <= deliver | (pend_reg & ~i_pend_clr); // RULE9
      end
   end

   cir_prio u_prio
   (
      .i_clk    (i_clk),
      .i_rst_n  (i_rst_n),
      .i_req    (pend_reg), // RULE6 RULE18
      .o_irq    (o_irq),
      .o_vector (o_vector)
   );

   // Raw synchronised inputs feed the chain, skipping local control logic.
   assign src_vec = {i_sw_pulse, ext_s2_reg}; // RULE15 RULE16
   assign src_wide = N_LINE'(src_vec);

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         chain_reg <= '0;
         out_reg   <= '0;
      end
      else
      begin
         for (int c = 0; c < N_CHAIN; c++)
         begin
            chain_reg[c] <= i_chain_route[c] // RULE14
               & pick_bit(src_wide, i_chain_src[c*SRC_W +: SRC_W], N_SRC);
         end
         for (int o = 0; o < N_OUT; o++)
         begin
            out_reg[o] <= i_out_route[o] // RULE17
               & pick_bit(line_in, i_out_src[o*LINE_W +: LINE_W], N_LINE);
         end
      end
   end

   assign o_chain   = chain_reg;
   assign o_ext_out = out_reg;
   assign o_pending = pend_reg;
   assign o_request = req_reg;

   sequence deliv_s(int k);
      req_reg[k] && i_arm[k] && i_enable[k] && !pend_reg[k];
   endsequence

   for (genvar g = 0; g < N_LINE; g++)
   begin : g_chk
      deliver_sets_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE1
         deliv_s(g) |=> pend_reg[g])
         else $error("delivery did not set pending");
      disarm_clears_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE5
         !i_arm[g] |=> !req_reg[g])
         else $error("disarm left a request");
      pend_needs_arm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
         $rose(pend_reg[g]) |-> $past(i_enable[g]) && $past(i_arm[g]))
         else $error("pending rose without arm and enable");
      pend_holds_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
         pend_reg[g] && !i_pend_clr[g] |=> pend_reg[g])
         else $error("pending dropped without host clear");
      held_req_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
         i_arm[g] && recog[g] |=> req_reg[g])
         else $error("armed line lost request");
      disabled_holds_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
         req_reg[g] && i_arm[g] && !i_enable[g] |=> req_reg[g])
         else $error("disabled line dropped its request");
      pend_blocks_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
         req_reg[g] && i_arm[g] && pend_reg[g] && !i_pend_clr[g] |=> req_reg[g] && pend_reg[g])
         else $error("request delivered while pending");
      pend_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
         pend_reg[g] && i_pend_clr[g] |=> !pend_reg[g])
         else $error("host clear left pending set");
      disarm_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE19
         !i_arm[g] |=> !$rose(pend_reg[g]))
         else $error("disarmed line became pending");
      en_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
         !i_enable[g] |=> !$rose(pend_reg[g]))
         else $error("disabled line became pending");
   end

   // Every chain line latches its rising edge, whoever drives it.
   for (genvar c = 0; c < N_CHAIN; c++)
   begin : g_chain_chk
      chain_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE17
         ch_view[c] && !ch_d_reg[c] && i_arm[N_EXT+c] |=> req_reg[N_EXT+c])
         else $error("chain edge not latched");
   end

   edge_once_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE11
      i_mode[1:0] == CIR_RISING && line_in[0] && line_prev[0] && !i_sw_req[0] |-> !recog[0])
      else $error("second request without deassert");
   chain_bypass_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE16
      i_chain_route[0] && ext_s2_reg[0] && i_chain_src[SRC_W-1:0] == '0 |=> o_chain[0])
      else $error("routed input did not reach chain");
   irq_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE14
      |pend_reg |=> o_irq)
      else $error("pending without host interrupt");

   sequence fall_seen_s;
      i_mode[1:0] == CIR_FALLING && !line_in[0] && line_prev[0];
   endsequence

   sequence rise_seen_s;
      i_mode[1:0] == CIR_RISING && line_in[0] && !line_prev[0];
   endsequence

   sequence irq_up_s;
      o_irq && o_vector == '0;
   endsequence

   // Line 0 stands for every external line, since all share one mode decode.
   fall_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE10
      fall_seen_s ##0 i_arm[0] |=> req_reg[0])
      else $error("falling edge not latched");
   rise_edge_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE10
      rise_seen_s ##0 i_arm[0] |=> req_reg[0])
      else $error("rising edge not latched");
   level_high_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE12
      i_mode[1:0] == CIR_HIGH && line_in[0] && i_arm[0] |=> req_reg[0])
      else $error("high level not latched");
   level_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE12
      i_mode[1:0] == CIR_LOW && !line_in[0] && i_arm[0] |=> req_reg[0])
      else $error("low level not latched");
   deliver_path_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE18
      deliv_s(0) |=> pend_reg[0] ##1 irq_up_s)
      else $error("line delivery missed its vector");
   vector_none_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
      !(|pend_reg) |=> !o_irq && o_vector == NO_LINE)
      else $error("host interrupt without pending line");
   sw_req_local_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE15
      i_sw_req[0] && i_arm[0] |=> req_reg[0])
      else $error("software request not latched");
   sw_local_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE15
      i_chain_route[0] && i_chain_src[SRC_W-1:0] == '0 |=> o_chain[0] == $past(ext_s2_reg[0]))
      else $error("chain output not the raw input");
   chain_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE16
      !i_chain_route[0] |=> !o_chain[0])
      else $error("unrouted chain output driven");
   ext_out_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE17
      i_out_route[0] && i_out_src[LINE_W-1:0] == LINE_W'(N_EXT)
         |=> o_ext_out[0] == $past(ch_view[0]))
      else $error("external output not the chain line");
   out_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE17
      !i_out_route[0] |=> !o_ext_out[0])
      else $error("unrouted external output driven");
   sync_stage_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE22
      ext_s2_reg == $past(ext_s1_reg))
      else $error("synchroniser stage skipped");
endmodule

//--- bench/cir_host_model.sv
// Host handler model: services the reported line, then clears its pending bit.
// Assumes irq with a valid vector whenever anything is pending.
`timescale 1ns/1ns
module cir_host_model
   import cir_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_irq,
   input  wire logic [LINE_W-1:0] i_vector,
   input  wire logic              i_en,
   input  wire logic [3:0]        i_delay,
   output logic [N_LINE-1:0]      o_pend_clr
);
   int                count [N_LINE];
   logic              busy_reg;
   logic [4:0]        wait_reg;
   logic [LINE_W-1:0] vec_reg;
   // The idle gap after a clear lets irq fall, so one delivery is served once.
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         busy_reg   <= 1'b0;
         wait_reg   <= 5'h0;
         vec_reg    <= '0;
         o_pend_clr <= '0;
      end
      else
      begin
         o_pend_clr <= '0;
         wait_reg   <= busy_reg ? wait_reg + 5'h1 : 5'h0;
         if (!busy_reg)
         begin
            busy_reg <= i_en && i_irq;
            vec_reg  <= i_vector;
         end
         else if (wait_reg == {1'b0, i_delay})
         begin
            o_pend_clr[vec_reg] <= 1'b1;
            count[vec_reg]      <= count[vec_reg] + 1;
         end
         else if (wait_reg == {1'b0, i_delay} + 5'h4)
            busy_reg <= 1'b0;
      end
   end
endmodule

//--- bench/test_cir_top.sv
// Bench for cir_top: drives pins and control levels, checks delivery at the ports.
// Assumes cir_host_model owns the pending clears and counts serviced lines.
`timescale 1ns/1ns
module test_cir_top
   import cir_pkg::*;
;
   logic                     i_clk = 1'b0;
   logic                     i_rst_n = 1'b0;
   logic                     srv = 1'b0;
   logic [3:0]               dly = 4'h2;
   logic [N_EXT-1:0]         i_ext = '1;
   logic [N_EXT-1:0]         i_sw_req = '0;
   logic [N_CHAIN-1:0]       i_chain = '0;
   logic [N_CHAIN-1:0]       i_chain_route = '0;
   logic [N_SW-1:0]          i_sw_pulse = '0;
   logic [N_LINE-1:0]        i_arm = '0;
   logic [N_LINE-1:0]        i_enable = '0;
   logic [2*N_EXT-1:0]       i_mode = '0;
   logic [N_CHAIN*SRC_W-1:0] i_chain_src = '0;
   logic [N_OUT*LINE_W-1:0]  i_out_src = '0;
   logic [N_OUT-1:0]         i_out_route = '0;
   logic [N_LINE-1:0]        clr, o_pending, o_request;
   logic [N_CHAIN-1:0]       o_chain;
   logic [N_OUT-1:0]         o_ext_out;
   logic                     o_irq;
   logic [LINE_W-1:0]        o_vector;
   int                       fails = 0;
   int                       total_checks = 0;
   int                       b0, b12;
   cir_top dut (.i_clk, .i_rst_n, .i_ext, .i_chain, .i_sw_pulse, .i_arm, .i_enable,
      .i_sw_req, .i_pend_clr(clr), .i_mode, .i_chain_src, .i_chain_route, .i_out_src,
      .i_out_route, .o_chain, .o_ext_out, .o_pending, .o_request, .o_irq, .o_vector);
   cir_host_model host (.i_clk, .i_rst_n, .i_irq(o_irq), .i_vector(o_vector),
      .i_en(srv), .i_delay(dly), .o_pend_clr(clr));
   always #4 i_clk = ~i_clk;
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic stop_test();
      if (fails == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge i_clk);
      fails++;
      stop_test();
   end
   initial
   begin
      cyc(5);
      i_rst_n = 1'b1;
      cyc(2);
      chk(o_pending, 0);
      chk(o_request, 0);
      chk({o_irq, o_vector}, {1'b0, NO_LINE});
      srv = 1'b1;
      i_arm = 20'h0_0002;
      i_enable = 20'h0_0002;
      // Bit 0 of every mode code is the active level; each value is held HOLD_CYC.
      for (int m = 0; m < 4; m++)
      begin
         dly = 4'(m * 3);
         i_mode[3:2] = m[1:0];
         i_ext[1] = ~m[0];
         cyc(HOLD_CYC);
         b0 = host.count[1];
         i_ext[1] = m[0];
         cyc(HOLD_CYC);
         i_ext[1] = ~m[0];
         cyc(HOLD_CYC);
         if (m < 2)
            chk(host.count[1] - b0, 1);
         else
            chk(host.count[1] - b0 > 1, 1);
      end
      srv = 1'b0;
      i_arm = 20'h0_1001;
      i_enable = 20'h0_0000;
      i_ext[0] = 1'b0;
      cyc(HOLD_CYC);
      chk({o_request[0], o_pending[0], o_irq}, 3'b100);
      i_enable[0] = 1'b1;
      cyc(3);
      chk({o_request[0], o_pending[0], o_irq}, 3'b011);
      i_ext[0] = 1'b1;
      cyc(HOLD_CYC);
      i_ext[0] = 1'b0;
      cyc(HOLD_CYC);
      chk({o_request[0], o_pending[0], o_irq}, 3'b111);
      b0 = host.count[0];
      srv = 1'b1;
      cyc(60);
      chk(host.count[0] - b0, 2);
      i_enable[0] = 1'b0;
      i_ext[0] = 1'b1;
      cyc(HOLD_CYC);
      i_ext[0] = 1'b0;
      cyc(HOLD_CYC);
      chk(o_request[0], 1'b1);
      i_arm[0] = 1'b0;
      cyc(2);
      chk(o_request[0], 1'b0);
      i_ext[0] = 1'b1;
      cyc(HOLD_CYC);
      i_ext[0] = 1'b0;
      cyc(HOLD_CYC);
      chk({o_request[0], o_pending[0]}, 2'b00);
      i_enable = 20'h0_1000;
      i_chain_src[9:5] = 5'd12;
      i_chain_route = 8'h03;
      i_out_src[4:0] = 5'd12;
      i_out_route = 4'h1;
      b12 = host.count[12];
      i_ext[0] = 1'b1;
      i_sw_pulse[0] = 1'b1;
      i_chain[0] = 1'b1;
      cyc(6);
      chk(o_chain[0], 1'b1);
      chk(o_chain[1], 1'b1);
      chk(o_ext_out[0], 1'b1);
      i_ext[0] = 1'b0;
      cyc(HOLD_CYC);
      chk(o_chain[0], 1'b0);
      chk(host.count[12] - b12, 1);
      i_arm[0] = 1'b1;
      i_enable[0] = 1'b1;
      b0 = host.count[0];
      i_sw_req[0] = 1'b1;
      cyc(1);
      i_sw_req[0] = 1'b0;
      cyc(3);
      chk(o_chain[0], 1'b0);
      cyc(40);
      chk(host.count[0] - b0, 1);
      // Input 2 also drives chain line 2; the second pass has that chain line disarmed.
      i_chain_src[14:10] = 5'd2;
      i_chain_route[2] = 1'b1;
      cyc(4);
      b0 = host.count[2];
      b12 = host.count[14];
      i_arm[2] = 1'b1;
      i_arm[14] = 1'b1;
      i_enable[2] = 1'b1;
      i_enable[14] = 1'b1;
      for (int r = 0; r < 2; r++)
      begin
         i_ext[2] = 1'b0;
         cyc(HOLD_CYC);
         i_ext[2] = 1'b1;
         cyc(HOLD_CYC);
         chk(host.count[2] - b0, r + 1);
         chk(host.count[14] - b12, 1);
         i_arm[14] = 1'b0;
      end
      stop_test();
   end
endmodule
